/* include/aic_defines.vh */
// Register offsets, field layouts and constants of the converter control block
`ifndef AIC_DEFINES_VH
`define AIC_DEFINES_VH

// Register word offsets on the Avalon-MM slave
`define AIC_REG_CTRL      4'h0
`define AIC_REG_AVG       4'h1
`define AIC_REG_RAW       4'h2
`define AIC_REG_MASKED    4'h3
`define AIC_REG_ENABLE    4'h4
`define AIC_REG_CLEAR     4'h5
`define AIC_REG_VIEW      4'h6
`define AIC_REG_CMP_RST   4'h7
`define AIC_REG_LOW_THR   4'h8
`define AIC_REG_HIGH_THR  4'h9
`define AIC_REG_BAND      4'ha
`define AIC_REG_RESULT    4'hb

// Word address field of the byte address
`define AIC_ADDR_LSB      2
`define AIC_ADDR_MSB      5

// Interrupt status layout: done[3:0], dma[7:4], compare[11:8]
`define AIC_DONE_LSB      0
`define AIC_DMA_LSB       4
`define AIC_CMP_LSB       8
`define AIC_NUM_SRC       12

// Control register bit positions
`define AIC_CTRL_VIEW_BIT 0

// Averaging code: 0 off, 1..6 give 2x..64x
`define AIC_AVG_OFF       3'h0
`define AIC_AVG_MAX       3'h6

// Comparator band encoding
`define AIC_BAND_NONE     2'h0
`define AIC_BAND_LOW      2'h1
`define AIC_BAND_MID      2'h2
`define AIC_BAND_HIGH     2'h3

// Reset values
`define AIC_THR_LOW_RST   12'h000
`define AIC_THR_HIGH_RST  12'hfff
`define AIC_ZERO32        32'h0000_0000

`endif

/* rtl/aic_averager.v */
// Hardware averaging of consecutive conversions from one input
`timescale 1ns/1ps
`include "aic_defines.vh"

module aic_averager #(
    parameter DATA_W = 12
) (
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Setting
    input wire [2:0] averaging_factor,
    // Raw conversion in
    input wire conv_valid,
    input wire [DATA_W-1:0] conv_data,
    // Averaged result out
    output reg avg_valid_r,
    output reg [DATA_W-1:0] avg_data_r
);

    localparam SUM_W = DATA_W + 6;

    reg [SUM_W-1:0] sum_r;
    reg [6:0] count_r;
    wire [6:0] target;
    wire [SUM_W-1:0] sum_nxt;
    wire [SUM_W-1:0] shifted;

    assign target = 7'h01 << averaging_factor;
    assign sum_nxt = sum_r + {6'h00, conv_data};
    assign shifted = sum_nxt >> averaging_factor;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            sum_r <= {SUM_W{1'b0}};
            count_r <= 7'h00;
            avg_valid_r <= 1'b0;
            avg_data_r <= {DATA_W{1'b0}};
        end else begin
            avg_valid_r <= 1'b0;
            if (conv_valid) begin
                if (averaging_factor == `AIC_AVG_OFF) begin
                    // Pass each conversion through alone
                    avg_valid_r <= 1'b1; // RULE_02
                    avg_data_r <= conv_data;
                    sum_r <= {SUM_W{1'b0}};
                    count_r <= 7'h00;
                end else if (count_r + 7'h01 >= target) begin
                    // One entry per completed group
                    avg_valid_r <= 1'b1; // RULE_04
                    avg_data_r <= shifted[DATA_W-1:0]; // RULE_17
                    sum_r <= {SUM_W{1'b0}};
                    count_r <= 7'h00; // RULE_05
                end else begin
                    sum_r <= sum_nxt; // RULE_01
                    count_r <= count_r + 7'h01;
                end
            end
        end
    end

endmodule // aic_averager

/* rtl/aic_comparator.v */
// Digital comparator band classification with resettable history
`timescale 1ns/1ps
`include "aic_defines.vh"

module aic_comparator #(
    parameter DATA_W = 12
) (
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Thresholds and history reset
    input wire [DATA_W-1:0] low_band_threshold,
    input wire [DATA_W-1:0] high_band_threshold,
    input wire history_clear,
    // Sample in
    input wire sample_valid,
    input wire [DATA_W-1:0] sample_data,
    // Classification out
    output reg [1:0] band_r,
    output reg band_change_r
);

    reg [1:0] band_nxt;

    always @* begin
        if (sample_data <= low_band_threshold)
            band_nxt = `AIC_BAND_LOW; // RULE_16
        else if (sample_data <= high_band_threshold)
            band_nxt = `AIC_BAND_MID;
        else
            band_nxt = `AIC_BAND_HIGH;
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            band_r <= `AIC_BAND_NONE;
            band_change_r <= 1'b0;
        end else begin
            band_change_r <= 1'b0;
            if (history_clear) begin
                band_r <= `AIC_BAND_NONE; // RULE_06
            end else if (sample_valid) begin
                band_r <= band_nxt;
                band_change_r <= (band_nxt != band_r);
            end
        end
    end

endmodule // aic_comparator

/* rtl/aic_ctrl.v */
// Converter control: averaging, comparator history and interrupt sources
//
// Function
// RULE_01: Average 2, 4, 8, 16, 32, 64 conversions
// RULE_02: Factor zero passes single conversions through
// RULE_03: One averaging setting for all sequencers
// RULE_04: Only averaged result enters the FIFO
// RULE_05: Result rate drops by the factor
// RULE_06: Comparator reset clears previous-value history
// RULE_07: Clearing a sequence interrupt deasserts it
// RULE_08: Twelve sources: done, DMA, compare per sequencer
// RULE_09: Only enabled sources reach the interrupt line
// RULE_10: Software clears stale status before enabling
// RULE_11: Raw and masked status per sequence
// RULE_12: Whole status view, raw or masked selectable
// RULE_13: Bulk clear by bit mask, one access
// RULE_14: Software clears source early in handler
// RULE_15: Compare status kept per comparator
// RULE_16: Low, mid, high band by two thresholds
// RULE_17: Average is sum shifted by log2 factor
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "aic_defines.vh"

module aic_ctrl #(
    parameter DATA_W = 12,
    parameter NUM_SEQ = 4
) (
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Avalon-MM slave
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Conversion stream from the converter core
    input wire [NUM_SEQ-1:0] conv_valid,
    input wire [DATA_W-1:0] conv_data,
    input wire [NUM_SEQ-1:0] seq_done,
    input wire [NUM_SEQ-1:0] dma_done,
    // Averaged results toward the sequencer FIFOs
    output reg [NUM_SEQ-1:0] fifo_wr_r,
    output reg [DATA_W-1:0] fifo_data_r,
    // Interrupt to the processor
    output reg irq_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    reg [2:0] avg_factor_r;
    reg view_sel_r;
    reg [`AIC_NUM_SRC-1:0] raw_r;
    reg [`AIC_NUM_SRC-1:0] enable_r;
    reg [DATA_W-1:0] low_thr_r;
    reg [DATA_W-1:0] high_thr_r;
    reg [NUM_SEQ-1:0] cmp_clear_r;
    reg ack_r;

    wire [3:0] word_addr;
    wire wr_hit;
    wire rd_hit;
    wire [`AIC_NUM_SRC-1:0] masked;
    wire [`AIC_NUM_SRC-1:0] clear_mask;
    wire [`AIC_NUM_SRC-1:0] set_mask;

    assign word_addr = avs_address[`AIC_ADDR_MSB:`AIC_ADDR_LSB];
    assign wr_hit = avs_write && !ack_r;
    assign rd_hit = avs_read && !ack_r;
    assign masked = raw_r & enable_r; // RULE_11

    ////////////////////////////////////////////////////////////////////////////
    // Averaging and comparators per sequencer

    wire [NUM_SEQ-1:0] avg_valid;
    wire [DATA_W*NUM_SEQ-1:0] avg_data;
    wire [2*NUM_SEQ-1:0] bands;
    wire [NUM_SEQ-1:0] band_change;

    genvar g;
    generate
        for (g = 0; g < NUM_SEQ; g = g + 1) begin : g_seq
            // All sequencers share the single averaging factor
            aic_averager #(
                .DATA_W(DATA_W)
            ) u_avg (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .averaging_factor(avg_factor_r), // RULE_03
                .conv_valid(conv_valid[g]),
                .conv_data(conv_data),
                .avg_valid_r(avg_valid[g]),
                .avg_data_r(avg_data[g*DATA_W +: DATA_W])
            );

            aic_comparator #(
                .DATA_W(DATA_W)
            ) u_cmp (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .low_band_threshold(low_thr_r),
                .high_band_threshold(high_thr_r),
                .history_clear(cmp_clear_r[g]), // RULE_06
                .sample_valid(avg_valid[g]),
                .sample_data(avg_data[g*DATA_W +: DATA_W]),
                .band_r(bands[2*g +: 2]),
                .band_change_r(band_change[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // FIFO write path

    reg [DATA_W-1:0] sel_data;
    integer i;

    always @* begin
        sel_data = {DATA_W{1'b0}};
        for (i = 0; i < NUM_SEQ; i = i + 1) begin
            if (avg_valid[i])
                sel_data = avg_data[i*DATA_W +: DATA_W];
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            fifo_wr_r <= {NUM_SEQ{1'b0}};
            fifo_data_r <= {DATA_W{1'b0}};
        end else begin
            fifo_wr_r <= avg_valid; // RULE_04
            fifo_data_r <= sel_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt sources

    // Compare source per comparator, set on band change
    assign set_mask = {band_change, dma_done, seq_done}; // RULE_08 RULE_15
    assign clear_mask = (wr_hit && word_addr == `AIC_REG_CLEAR) ?
        avs_writedata[`AIC_NUM_SRC-1:0] : {`AIC_NUM_SRC{1'b0}}; // RULE_13

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            raw_r <= {`AIC_NUM_SRC{1'b0}};
            irq_r <= 1'b0;
        end else begin
            // Event in the clearing cycle wins over the clear
            raw_r <= (raw_r & ~clear_mask) | set_mask; // RULE_07
            irq_r <= |(((raw_r & ~clear_mask) | set_mask) & enable_r); // RULE_09
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            avg_factor_r <= `AIC_AVG_OFF;
            view_sel_r <= 1'b0;
            enable_r <= {`AIC_NUM_SRC{1'b0}};
            low_thr_r <= `AIC_THR_LOW_RST;
            high_thr_r <= `AIC_THR_HIGH_RST;
            cmp_clear_r <= {NUM_SEQ{1'b0}};
        end else begin
            cmp_clear_r <= {NUM_SEQ{1'b0}};
            if (wr_hit && avs_byteenable[0]) begin
                case (word_addr)
                    `AIC_REG_CTRL: view_sel_r <= avs_writedata[`AIC_CTRL_VIEW_BIT];
                    `AIC_REG_AVG: begin
                        if (avs_writedata[2:0] <= `AIC_AVG_MAX)
                            avg_factor_r <= avs_writedata[2:0]; // RULE_01
                    end
                    `AIC_REG_ENABLE: enable_r <= avs_writedata[`AIC_NUM_SRC-1:0];
                    `AIC_REG_CMP_RST: cmp_clear_r <= avs_writedata[NUM_SEQ-1:0];
                    `AIC_REG_LOW_THR: low_thr_r <= avs_writedata[DATA_W-1:0];
                    `AIC_REG_HIGH_THR: high_thr_r <= avs_writedata[DATA_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait cycle, then ack

    reg [31:0] rd_nxt;

    always @* begin
        rd_nxt = `AIC_ZERO32;
        case (word_addr)
            `AIC_REG_CTRL: rd_nxt[0] = view_sel_r;
            `AIC_REG_AVG: rd_nxt[2:0] = avg_factor_r;
            `AIC_REG_RAW: rd_nxt[`AIC_NUM_SRC-1:0] = raw_r;
            `AIC_REG_MASKED: rd_nxt[`AIC_NUM_SRC-1:0] = masked;
            `AIC_REG_ENABLE: rd_nxt[`AIC_NUM_SRC-1:0] = enable_r;
            `AIC_REG_VIEW: rd_nxt[`AIC_NUM_SRC-1:0] = view_sel_r ? masked : raw_r; // RULE_12
            `AIC_REG_LOW_THR: rd_nxt[DATA_W-1:0] = low_thr_r;
            `AIC_REG_HIGH_THR: rd_nxt[DATA_W-1:0] = high_thr_r;
            `AIC_REG_BAND: rd_nxt[2*NUM_SEQ-1:0] = bands;
            `AIC_REG_RESULT: rd_nxt[DATA_W-1:0] = fifo_data_r;
            default: rd_nxt = `AIC_ZERO32;
        endcase
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= `AIC_ZERO32;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
            if (rd_hit)
                avs_readdata <= rd_nxt;
        end
    end

endmodule // aic_ctrl

/* tb/aic_ctrl_monitor.sv */
// Assertion checker for the converter control block
`timescale 1ns/1ps
module aic_ctrl_monitor #(
    parameter NUM_SEQ = 4
) (
    // Clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // Register bus
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Stream and interrupt
    input wire [NUM_SEQ-1:0] conv_valid,
    input wire [NUM_SEQ-1:0] seq_done,
    input wire [NUM_SEQ-1:0] dma_done,
    input wire [NUM_SEQ-1:0] fifo_wr_r,
    input wire irq_r
);
    reg [2:0] code_r;
    reg [11:0] en_r;
    reg [6:0] cnt_r;
    wire wr_w = avs_write && avs_waitrequest;
    wire last_w = cnt_r == (7'h01 << code_r) - 7'h01;
    // Shadow of the averaging code, the enables and the group position of sequencer 0
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            code_r <= 3'h0;
            en_r <= 12'h000;
            cnt_r <= 7'h00;
        end else begin
            if (wr_w && avs_address[5:2] == 4'h1 && avs_writedata[2:0] <= 3'h6)
                code_r <= avs_writedata[2:0];
            if (wr_w && avs_address[5:2] == 4'h4)
                en_r <= avs_writedata[11:0];
            if (wr_w && avs_address[5:2] == 4'h1)
                cnt_r <= 7'h00;
            else if (conv_valid[0])
                cnt_r <= last_w ? 7'h00 : cnt_r + 7'h01;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_ack;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("access not answered next cycle");
    property p_ack_once;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("answer longer than one cycle");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address[5:2] > 4'hb |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_avg_rate;
        fifo_wr_r[0] == ($past(conv_valid[0], 2) && $past(last_w, 2));
    endproperty
    a_avg_rate: assert property (p_avg_rate) else $error("fifo write off group end");
    property p_fifo_cause;
        (fifo_wr_r & ~$past(conv_valid, 2)) == '0;
    endproperty
    a_fifo_cause: assert property (p_fifo_cause) else $error("fifo write without sample");
    property p_src_irq;
        ((seq_done & en_r[3:0]) | (dma_done & en_r[7:4])) != 4'h0 |-> ##[1:3] irq_r;
    endproperty
    a_src_irq: assert property (p_src_irq) else $error("enabled event no interrupt");
    property p_irq_masked;
        (en_r == 12'h000) [*3] |-> !irq_r;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt while disabled");
    property p_clear;
        wr_w && avs_address[5:2] == 4'h5 && avs_writedata[11:0] == 12'hfff && seq_done == 0
            && dma_done == 0 && conv_valid == 0 && fifo_wr_r == 0 |-> ##2 !irq_r;
    endproperty
    a_clear: assert property (p_clear) else $error("bulk clear left interrupt");
endmodule // aic_ctrl_monitor

bind aic_ctrl aic_ctrl_monitor #(.NUM_SEQ(NUM_SEQ)) aic_ctrl_monitor_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_valid(conv_valid), .seq_done(seq_done),
    .dma_done(dma_done), .fifo_wr_r(fifo_wr_r), .irq_r(irq_r));

/* tb/aic_conv_model.sv */
// Converter core model: conversion and event pulses
`timescale 1ns/1ps
module aic_conv_model (
    // Clock
    input wire sys_clk,
    // Stream toward the block
    output logic [3:0] conv_valid,
    output logic [11:0] conv_data,
    output logic [3:0] seq_done,
    output logic [3:0] dma_done
);
    initial begin
        conv_valid = 4'h0;
        conv_data = 12'h000;
        seq_done = 4'h0;
        dma_done = 4'h0;
    end
    // One-cycle pulse; data is scrambled outside it
    task automatic pulse(input logic [3:0] cv, input logic [11:0] d, input logic [3:0] sd,
                         input logic [3:0] dd);
        @(posedge sys_clk);
        conv_valid <= cv;
        conv_data <= d;
        seq_done <= sd;
        dma_done <= dd;
        @(posedge sys_clk);
        conv_valid <= 4'h0;
        conv_data <= ~d;
        seq_done <= 4'h0;
        dma_done <= 4'h0;
    endtask
endmodule // aic_conv_model

/* tb/aic_ctrl_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module aic_ctrl_tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, irq_r;
    logic [3:0] conv_valid, seq_done, dma_done, fifo_wr_r;
    logic [11:0] conv_data, fifo_data_r, v;
    logic [11:0] last_d [4];
    logic [11:0] bv [4] = '{12'h100, 12'h101, 12'h200, 12'h201};
    logic [1:0] bb [4] = '{2'h1, 2'h2, 2'h2, 2'h3};
    int wr_cnt [4] = '{0, 0, 0, 0};
    int failures = 0;
    int n_checks = 0;
    int n0, n1, s;
    always #50 sys_clk = ~sys_clk;
    aic_ctrl aic_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .conv_valid(conv_valid), .conv_data(conv_data), .seq_done(seq_done),
        .dma_done(dma_done), .fifo_wr_r(fifo_wr_r), .fifo_data_r(fifo_data_r), .irq_r(irq_r));
    aic_conv_model aic_conv_model_i (.sys_clk(sys_clk), .conv_valid(conv_valid),
        .conv_data(conv_data), .seq_done(seq_done), .dma_done(dma_done));
    always @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (fifo_wr_r[i] === 1'b1) begin
                wr_cnt[i] += 1;
                last_d[i] = fifo_data_r;
            end
        end
    end
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Hold the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= {w, 2'b00};
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 50)
            chk(1'b1, 1'b0);
        // Read data is taken at the same edge that samples waitrequest low
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] w, input logic [31:0] exp);
        bus(1'b0, w, 32'h0);
        chk(q, exp);
    endtask
    task automatic irq_is(input logic e);
        @(negedge sys_clk);
        chk(irq_r, e);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        wrap_up;
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdc(4'h8, 32'h0);
        rdc(4'h9, 32'hfff);
        bus(1'b1, 4'hc, 32'h5a);
        rdc(4'hc, 32'h0);
        for (int k = 0; k < 7; k++) begin
            n0 = wr_cnt[0];
            n1 = wr_cnt[1];
            s = 0;
            bus(1'b1, 4'h1, k);
            for (int i = 0; i < (2 << k); i++) begin
                v = 12'(256 + i * 5);
                if (i == (1 << k))
                    s = 0;
                s += v;
                aic_conv_model_i.pulse(4'h3, v, 4'h0, 4'h0);
            end
            repeat (4) @(posedge sys_clk);
            chk(wr_cnt[0] - n0, 2);
            chk(wr_cnt[1] - n1, 2);
            chk(last_d[0], s >> k);
            rdc(4'h1, k);
        end
        bus(1'b1, 4'h1, 32'h7);
        rdc(4'h1, 32'h6);
        bus(1'b1, 4'h1, 32'h0);
        bus(1'b1, 4'h5, 32'hfff);
        rdc(4'h2, 32'h0);
        aic_conv_model_i.pulse(4'h0, 12'h000, 4'h5, 4'ha);
        rdc(4'h2, 32'ha5);
        rdc(4'h3, 32'h0);
        irq_is(1'b0);
        bus(1'b1, 4'h4, 32'h1);
        rdc(4'h3, 32'h1);
        rdc(4'h6, 32'ha5);
        bus(1'b1, 4'h0, 32'h1);
        rdc(4'h6, 32'h1);
        irq_is(1'b1);
        bus(1'b1, 4'h5, 32'h1);
        rdc(4'h2, 32'ha4);
        irq_is(1'b0);
        bus(1'b1, 4'h5, 32'ha4);
        rdc(4'h2, 32'h0);
        bus(1'b1, 4'h8, 32'h100);
        bus(1'b1, 4'h9, 32'h200);
        bus(1'b1, 4'h4, 32'h400);
        for (int j = 0; j < 4; j++) begin
            aic_conv_model_i.pulse(4'h4, bv[j], 4'h0, 4'h0);
            repeat (4) @(posedge sys_clk);
            bus(1'b0, 4'ha, 32'h0);
            chk(q[5:4], bb[j]);
        end
        rdc(4'h2, 32'h400);
        irq_is(1'b1);
        bus(1'b1, 4'h5, 32'hfff);
        bus(1'b1, 4'h7, 32'h4);
        bus(1'b0, 4'ha, 32'h0);
        chk(q[5:4], 2'h0);
        aic_conv_model_i.pulse(4'h4, 12'h201, 4'h0, 4'h0);
        repeat (4) @(posedge sys_clk);
        rdc(4'h2, 32'h400);
        bus(1'b1, 4'h4, 32'hff);
        aic_conv_model_i.pulse(4'h0, 12'h000, 4'h2, 4'h0);
        irq_is(1'b1);
        wrap_up;
    end
endmodule // aic_ctrl_tb
